// *** hw/slc_cfg.svh ***
// Offsets, field positions and reset values of the lane datapath
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH
`define SLC_IDX_GLOBAL 6'h10
`define SLC_IDX_LANE0 6'h11
`define SLC_IDX_LANE3 6'h14
`define SLC_IDX_STATUS 6'h16
`define SLC_GB_CTC_EN 11
`define SLC_GB_RPT_HI 10
`define SLC_GB_RPT_LO 9
`define SLC_GB_INDEP 8
`define SLC_GB_ENC_EN 7
`define SLC_GB_MODE_OVR 3
`define SLC_LB_PRE_HI 5
`define SLC_LB_PRE_LO 4
`define SLC_LB_PRBS 2
`define SLC_GCFG_RST 12'h880
`define SLC_LCFG_RST 6'h00
`define SLC_RPT_PASS 2'h1
`define SLC_WORD_BITS 4'hA
`define SLC_CHR_A 8'h7C
`define SLC_CHR_K 8'hBC
`define SLC_CHR_R 8'h1C
`define SLC_CHR_IDLE 8'h07
`define SLC_FIFO_DEL_LVL 3'h3
`define SLC_FIFO_FULL 3'h4
`endif

// *** hw/slc_pkg.sv ***
// Types of the lane datapath
package slc_pkg;
   typedef enum logic [3:0] {
      SLC_FULL = 4'h1,
      SLC_TXONLY = 4'h2,
      SLC_RXONLY = 4'h4,
      SLC_RPT = 4'h8
   } slc_mode_t;
   typedef struct packed {
      logic [9:0] sh;
      logic [6:0] pgen;
      logic [9:0] des;
      logic [3:0] dcnt;
      logic [6:0] hist;
      logic [2:0] hcnt;
      logic pass;
      logic [9:0] rxw;
      logic rstb;
      logic sout;
   } slc_lane_st_t;
   typedef struct packed {
      logic [3:0] bcnt;
      slc_mode_t mode;
      logic [11:0] gcfg;
      logic [3:0][5:0] lcfg;
      logic [31:0] prdata;
      logic [3:0][35:0] fifo;
      logic [2:0] wptr;
      logic [2:0] rptr;
      logic [39:0] rxd;
      logic [3:0] rxv;
      logic [3:0] mf;
      logic [3:0] ins_cnt;
      logic [3:0] del_cnt;
   } slc_top_st_t;
endpackage

// *** hw/slc_lane.sv ***
// One lane: serializer, deserializer, PRBS generator and checker
`timescale 1ns/1ps
`include "slc_cfg.svh"
module slc_lane (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Transmit side
   input wire logic i_load,
   input wire logic [9:0] i_word,
   input wire logic i_prbs_en,
   input wire logic i_rpt,
   output logic o_ser_out,
   // Receive side
   input wire logic i_ser_in,
   input wire logic i_sync_en,
   output logic [9:0] o_rx_word,
   output logic o_rx_stb,
   output logic o_pass
);
   slc_pkg::slc_lane_st_t st_r;
   slc_pkg::slc_lane_st_t st_nxt;
   logic [9:0] gen_word;
   logic [6:0] gen_next;
   logic exp_bit;
   logic err;

   // Ten steps of the x^7+x^6+1 sequence per word
   always_comb begin
      logic [6:0] s;
      s = st_r.pgen;
      gen_word = 10'h000;
      for (int i = 0; i < 10; i++) begin
         gen_word[i] = s[6] ^ s[5];
         s = {s[5:0], gen_word[i]};
      end
      gen_next = s;
   end

   assign exp_bit = st_r.hist[6] ^ st_r.hist[5];
   assign err = (st_r.hcnt == 3'h7) && (i_ser_in != exp_bit);

   always_comb begin
      st_nxt = st_r;
      st_nxt.rstb = 1'b0;
      if (i_load) begin
         st_nxt.pgen = gen_next;
         // Self-test replaces bus data at the serializer input
         if (i_prbs_en) begin
            st_nxt.sout = gen_word[0];
            st_nxt.sh = {1'b0, gen_word[9:1]};
         end else begin
            st_nxt.sout = i_word[0];
            st_nxt.sh = {1'b0, i_word[9:1]};
         end
      end else begin
         st_nxt.sout = st_r.sh[0];
         st_nxt.sh = {1'b0, st_r.sh[9:1]};
      end
      if (i_rpt) begin
         st_nxt.sout = i_ser_in;
      end
      // Receive bits arrive LSB first
      st_nxt.des = {i_ser_in, st_r.des[9:1]};
      if (st_r.dcnt == `SLC_WORD_BITS - 4'h1) begin
         st_nxt.dcnt = 4'h0;
         st_nxt.rxw = {i_ser_in, st_r.des[9:1]};
         st_nxt.rstb = 1'b1;
      end else begin
         st_nxt.dcnt = st_r.dcnt + 4'h1;
      end
      st_nxt.hist = {st_r.hist[5:0], i_ser_in};
      if (st_r.hcnt != 3'h7) begin
         st_nxt.hcnt = st_r.hcnt + 3'h1;
      end
      if (i_sync_en) begin
         st_nxt.pass = st_r.pass & ~err;
      end else begin
         st_nxt.pass = ~err;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '{pgen: 7'h7F, pass: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_ser_out = st_r.sout;
   assign o_rx_word = st_r.rxw;
   assign o_rx_stb = st_r.rstb;
   assign o_pass = st_r.pass;

   a_pass_latched: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!o_pass && i_sync_en) |=> !o_pass)
      else $error("pass flag released while sync enabled");
   a_lsb_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_load && !i_prbs_en && !i_rpt) |=> (o_ser_out == $past(i_word[0])))
      else $error("serializer did not send the word LSB first");
   a_err_drops: assert property (@(posedge i_clk) disable iff (!i_nrst)
      err |=> !o_pass)
      else $error("bit error did not clear pass flag");
endmodule

// *** hw/slc_top.sv ***
// Four-lane datapath control: CLOCK_TOLERANCE_COMP, serializers, modes, self-test, APB registers
`timescale 1ns/1ps
`include "slc_cfg.svh"
module slc_top (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Configuration pins
   input wire logic i_mode_select_pin_a,
   input wire logic i_mode_select_pin_b,
   input wire logic i_selftest_enable_pin,
   input wire logic i_sync_enable_input,
   // Transmit parallel side
   input wire logic [39:0] i_transmit_lane_data,
   input wire logic [39:0] i_enc_word,
   output logic o_word_load,
   // Serial link
   input wire logic [3:0] i_serial_receive_pair,
   output logic [3:0] o_ser_out,
   output logic [3:0] o_ser_out_en,
   output logic [3:0] o_preemph_sel_low,
   output logic [3:0] o_preemph_sel_high,
   // Receive parallel side
   input wire logic [31:0] i_rx_dec_data,
   input wire logic [3:0] i_rx_dec_k,
   input wire logic i_rx_dec_valid,
   output logic [39:0] o_rx_data,
   output logic [3:0] o_rx_valid,
   output logic o_rx_data_en,
   // Self-test report and power
   output logic [3:0] o_lane_multifunction_output,
   output logic o_pd_tx,
   output logic o_pd_rx
);
   slc_pkg::slc_top_st_t st_r;
   slc_pkg::slc_top_st_t st_nxt;
   logic load;
   logic [3:0] lane_pass;
   logic [3:0] lane_stb;
   logic [39:0] lane_word;
   logic [3:0] ser_in;
   logic [39:0] tx_word;
   logic [3:0] prbs_en;
   logic [5:0] idx;
   logic mapped;
   logic wr;
   logic rd_setup;
   logic [2:0] level;
   logic all_r;
   logic ctc_en;
   logic indep;
   slc_pkg::slc_mode_t pin_mode;

   function automatic logic is_ctrl(input logic [7:0] b, input logic k);
      is_ctrl = k && (b == `SLC_CHR_A || b == `SLC_CHR_K || b == `SLC_CHR_R);
   endfunction

   // Bit clock divided by ten marks each reference period
   assign load = (st_r.bcnt == 4'h0);
   assign ctc_en = st_r.gcfg[`SLC_GB_CTC_EN];
   assign indep = st_r.gcfg[`SLC_GB_INDEP];
   assign level = st_r.wptr - st_r.rptr;
   assign idx = i_paddr[7:2];
   assign mapped = (idx >= `SLC_IDX_GLOBAL && idx <= `SLC_IDX_LANE3)
      || idx == `SLC_IDX_STATUS;
   assign wr = i_psel && i_penable && i_pwrite && mapped;
   assign rd_setup = i_psel && !i_penable && !i_pwrite;

   always_comb begin
      all_r = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (!(i_rx_dec_k[i] && i_rx_dec_data[i*8 +: 8] == `SLC_CHR_R)) begin
            all_r = 1'b0;
         end
      end
   end

   // Pins pick the mode unless software overrides
   always_comb begin
      unique case ({i_mode_select_pin_a, i_mode_select_pin_b})
         2'b00: pin_mode = slc_pkg::SLC_FULL;
         2'b01: pin_mode = slc_pkg::SLC_TXONLY;
         2'b10: pin_mode = slc_pkg::SLC_RXONLY;
         2'b11: pin_mode = slc_pkg::SLC_RPT;
      endcase
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         prbs_en[i] = i_selftest_enable_pin || st_r.lcfg[i][`SLC_LB_PRBS];
         ser_in[i] = (st_r.mode == slc_pkg::SLC_TXONLY) ? 1'b0 : i_serial_receive_pair[i];
         o_preemph_sel_low[i] = st_r.lcfg[i][`SLC_LB_PRE_LO];
         o_preemph_sel_high[i] = st_r.lcfg[i][`SLC_LB_PRE_HI];
      end
      if (st_r.mode == slc_pkg::SLC_RXONLY) begin
         tx_word = 40'h0000000000;
      end else if (st_r.gcfg[`SLC_GB_ENC_EN]) begin
         tx_word = i_enc_word;
      end else begin
         tx_word = i_transmit_lane_data;
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_lane
      slc_lane u_lane (
         .i_clk(i_clk),
         .i_nrst(i_nrst),
         .i_load(load),
         .i_word(tx_word[g*10 +: 10]),
         .i_prbs_en(prbs_en[g]),
         .i_rpt(st_r.mode == slc_pkg::SLC_RPT),
         .o_ser_out(o_ser_out[g]),
         .i_ser_in(ser_in[g]),
         .i_sync_en(i_sync_enable_input),
         .o_rx_word(lane_word[g*10 +: 10]),
         .o_rx_stb(lane_stb[g]),
         .o_pass(lane_pass[g])
      );
   end

   always_comb begin
      logic [35:0] col;
      col = 36'h000000000;
      st_nxt = st_r;
      st_nxt.bcnt = (st_r.bcnt == `SLC_WORD_BITS - 4'h1) ? 4'h0 : st_r.bcnt + 4'h1;
      if (st_r.gcfg[`SLC_GB_MODE_OVR]) begin
         unique case (st_r.gcfg[1:0])
            2'b00: st_nxt.mode = slc_pkg::SLC_FULL;
            2'b01: st_nxt.mode = slc_pkg::SLC_TXONLY;
            2'b10: st_nxt.mode = slc_pkg::SLC_RXONLY;
            2'b11: st_nxt.mode = slc_pkg::SLC_RPT;
         endcase
      end else begin
         st_nxt.mode = pin_mode;
      end
      // Register writes; global preemph and self-test bits reach all lanes
      if (wr) begin
         if (idx == `SLC_IDX_GLOBAL) begin
            st_nxt.gcfg = i_pwdata[11:0];
            for (int i = 0; i < 4; i++) begin
               st_nxt.lcfg[i][5:4] = i_pwdata[5:4];
               st_nxt.lcfg[i][2] = i_pwdata[2];
            end
         end else if (idx != `SLC_IDX_STATUS) begin
            st_nxt.lcfg[idx[1:0] - 2'h1] = i_pwdata[5:0];
         end
      end
      if (rd_setup) begin
         if (idx == `SLC_IDX_GLOBAL) begin
            st_nxt.prdata = {20'h00000, st_r.gcfg[11:6], st_r.lcfg[0][5:4],
               st_r.gcfg[3], st_r.lcfg[0][2], st_r.gcfg[1:0]};
         end else if (idx >= `SLC_IDX_LANE0 && idx <= `SLC_IDX_LANE3) begin
            st_nxt.prdata = {26'h0000000, st_r.lcfg[idx[1:0] - 2'h1]};
         end else if (idx == `SLC_IDX_STATUS) begin
            st_nxt.prdata = {9'h000, st_r.del_cnt, st_r.ins_cnt, level,
               st_r.mode, st_r.mf, lane_pass};
         end else begin
            st_nxt.prdata = 32'h00000000;
         end
      end
      // Synchronized receive: column FIFO, compensation on all lanes at once
      if (!indep && st_r.mode != slc_pkg::SLC_TXONLY) begin
         if (i_rx_dec_valid) begin
            if (ctc_en && all_r && level >= `SLC_FIFO_DEL_LVL) begin
               st_nxt.del_cnt = st_r.del_cnt + 4'h1;
            end else if (level != `SLC_FIFO_FULL) begin
               st_nxt.fifo[st_r.wptr[1:0]] = {i_rx_dec_k, i_rx_dec_data};
               st_nxt.wptr = st_r.wptr + 3'h1;
            end
         end
         if (lane_stb[0]) begin
            if (level != 3'h0) begin
               col = st_r.fifo[st_r.rptr[1:0]];
               st_nxt.rptr = st_r.rptr + 3'h1;
            end else begin
               col = {4'hF, {4{`SLC_CHR_R}}};
               if (ctc_en) begin
                  st_nxt.ins_cnt = st_r.ins_cnt + 4'h1;
               end
            end
            for (int i = 0; i < 4; i++) begin
               if (is_ctrl(col[i*8 +: 8], col[32 + i])) begin
                  st_nxt.rxd[i*10 +: 10] = {2'h1, `SLC_CHR_IDLE};
               end else begin
                  st_nxt.rxd[i*10 +: 10] = {1'b0, col[32 + i], col[i*8 +: 8]};
               end
            end
         end
         st_nxt.rxv = {4{lane_stb[0]}};
      end else if (indep && st_r.mode != slc_pkg::SLC_TXONLY) begin
         for (int i = 0; i < 4; i++) begin
            if (lane_stb[i]) begin
               st_nxt.rxd[i*10 +: 10] = lane_word[i*10 +: 10];
            end
         end
         st_nxt.rxv = lane_stb;
      end else begin
         st_nxt.rxv = 4'h0;
      end
      // Pass flags reach the pins only when reporting is selected
      if (st_r.gcfg[`SLC_GB_RPT_HI:`SLC_GB_RPT_LO] == `SLC_RPT_PASS) begin
         st_nxt.mf = lane_pass;
      end else begin
         st_nxt.mf = 4'h0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '{mode: slc_pkg::SLC_FULL, gcfg: `SLC_GCFG_RST,
            lcfg: {4{`SLC_LCFG_RST}}, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_prdata = st_r.prdata;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;
   assign o_word_load = load;
   assign o_ser_out_en = (st_r.mode == slc_pkg::SLC_RXONLY) ? 4'h0 : 4'hF;
   assign o_rx_data = st_r.rxd;
   assign o_rx_valid = st_r.rxv;
   assign o_rx_data_en = (st_r.mode != slc_pkg::SLC_TXONLY);
   assign o_lane_multifunction_output = st_r.mf;
   assign o_pd_tx = (st_r.mode == slc_pkg::SLC_RXONLY);
   assign o_pd_rx = (st_r.mode == slc_pkg::SLC_TXONLY);

   sequence s_load;
      load;
   endsequence
   sequence s_quiet_nine;
      !load [*8] ##1 !load;
   endsequence

   a_load_period: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_load |=> s_quiet_nine ##1 s_load)
      else $error("word load not every ten cycles");
   a_rx_idle_out: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (o_rx_valid[0] && !indep && !$past(indep)) |-> !is_ctrl(o_rx_data[7:0], o_rx_data[8]))
      else $error("control character reached the receive bus");
   a_ctc_drop: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_rx_dec_valid && all_r && ctc_en && !indep && level >= `SLC_FIFO_DEL_LVL
      && st_r.mode != slc_pkg::SLC_TXONLY) |=> (st_r.wptr == $past(st_r.wptr)))
      else $error("R column not dropped on a filling FIFO");
   a_rxonly_hiz: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.mode == slc_pkg::SLC_RXONLY) |-> (o_ser_out_en == 4'h0 && o_pd_tx))
      else $error("serial outputs driven in receive-only");
   a_txonly_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.mode == slc_pkg::SLC_TXONLY) [*2] |-> (o_rx_valid == 4'h0 && !o_rx_data_en))
      else $error("receive bus active in transmit-only");
   a_mf_report: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.gcfg[`SLC_GB_RPT_HI:`SLC_GB_RPT_LO] == `SLC_RPT_PASS)
      |=> (o_lane_multifunction_output == $past(lane_pass)))
      else $error("pass flags not reported");
   a_ctc_enable: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (lane_stb[0] && level == 3'h0 && !indep && !ctc_en
      && st_r.mode != slc_pkg::SLC_TXONLY) |=> $stable(st_r.ins_cnt))
      else $error("insertion counted with compensation off");

   // Mode pins, register override and power-down
   a_pin_full: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!st_r.gcfg[`SLC_GB_MODE_OVR] && !i_mode_select_pin_a && !i_mode_select_pin_b)
      |=> (st_r.mode == slc_pkg::SLC_FULL))
      else $error("both pins low did not give full duplex");
   a_ovr_mode: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.gcfg[`SLC_GB_MODE_OVR] && st_r.gcfg[1:0] == 2'h2)
      |=> (st_r.mode == slc_pkg::SLC_RXONLY))
      else $error("register mode select ignored");
   a_pd_split: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !(o_pd_tx && o_pd_rx) && (o_pd_rx == (st_r.mode == slc_pkg::SLC_TXONLY)))
      else $error("power-down does not follow the mode");

   // Unused directions are cut off from the data path; repeater resends serial input
   a_txonly_serin: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.mode == slc_pkg::SLC_TXONLY) |-> (ser_in == 4'h0))
      else $error("serial input used in transmit-only");
   a_rxonly_txword: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.mode == slc_pkg::SLC_RXONLY) |-> (tx_word == 40'h0000000000))
      else $error("transmit bus used in receive-only");
   a_rpt_pass: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.mode == slc_pkg::SLC_RPT) |=> (o_ser_out == $past(i_serial_receive_pair)))
      else $error("repeater did not resend serial input");

   // Synchronized output: lane A strobe, then one full column
   sequence s_lane_a_word;
      lane_stb[0] && !indep && st_r.mode != slc_pkg::SLC_TXONLY;
   endsequence
   sequence s_column_out;
      o_rx_valid == 4'hF;
   endsequence
   a_sync_column: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_lane_a_word |=> s_column_out)
      else $error("column not output on lane A strobe");
   a_empty_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_lane_a_word ##0 (level == 3'h0) |=> (o_rx_data == {4{2'h1, `SLC_CHR_IDLE}}))
      else $error("empty FIFO did not give an idle column");
   a_ins_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_lane_a_word ##0 (level == 3'h0 && ctc_en)
      |=> (st_r.ins_cnt == $past(st_r.ins_cnt) + 4'h1))
      else $error("insertion not counted");
   a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_nrst)
      level <= `SLC_FIFO_FULL)
      else $error("receive FIFO overflowed");

   // Independent lanes and pass reporting
   a_indep_raw: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (indep && lane_stb[1] && st_r.mode != slc_pkg::SLC_TXONLY)
      |=> (o_rx_valid[1] && o_rx_data[19:10] == $past(lane_word[19:10])))
      else $error("independent lane word not passed through");
   a_mf_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (st_r.gcfg[`SLC_GB_RPT_HI:`SLC_GB_RPT_LO] != `SLC_RPT_PASS)
      |=> (o_lane_multifunction_output == 4'h0))
      else $error("pass flags shown while reporting is off");
endmodule

// *** bench/slc_peer.sv ***
// Remote transceiver model: period-127 serial source on four lanes
`timescale 1ns/1ps
module slc_peer (
   // Clock
   input wire logic i_clk,
   // Bit error injection per lane
   input wire logic [3:0] i_err,
   // Serial lanes towards the device
   output logic [3:0] o_ser
);
   logic [6:0] lfsr_r;
   logic bit_w;
   initial lfsr_r = 7'h7F;
   initial o_ser = 4'h0;
   assign bit_w = lfsr_r[6] ^ lfsr_r[5];
   always @(posedge i_clk) begin
      lfsr_r <= {lfsr_r[5:0], bit_w};
      o_ser <= {4{bit_w}} ^ i_err;
   end
endmodule

// *** bench/slc_top_tb.sv ***
// Self-checking bench of the lane datapath
`timescale 1ns/1ps
module slc_top_tb;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pa = 1'b0;
   logic pb = 1'b0;
   logic ste = 1'b0;
   logic sen = 1'b0;
   logic [39:0] txd = {4{10'h0CA}};
   logic [39:0] encw = {4{10'h2B5}};
   logic [31:0] dd = 32'h0;
   logic [3:0] dk = 4'h0;
   logic dv = 1'b0;
   logic [3:0] err = 4'h0;
   logic wload;
   logic [3:0] ser_in, ser_out, ser_en, prl, prh, rxv, mf;
   logic [39:0] rxd;
   logic rx_en, pd_tx, pd_rx, er;
   logic [31:0] rd;
   logic [19:0] bits;
   logic [3:0] s0;
   int n_mismatch = 0;
   int n_tests = 0;
   int cnt = 0;

   always #2.5 i_clk = ~i_clk;

   slc_peer peer (.i_clk(i_clk), .i_err(err), .o_ser(ser_in));

   slc_top DUT (
      .i_clk(i_clk), .i_nrst(i_nrst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_mode_select_pin_a(pa), .i_mode_select_pin_b(pb),
      .i_selftest_enable_pin(ste), .i_sync_enable_input(sen),
      .i_transmit_lane_data(txd), .i_enc_word(encw), .o_word_load(wload),
      .i_serial_receive_pair(ser_in), .o_ser_out(ser_out), .o_ser_out_en(ser_en),
      .o_preemph_sel_low(prl), .o_preemph_sel_high(prh),
      .i_rx_dec_data(dd), .i_rx_dec_k(dk), .i_rx_dec_valid(dv),
      .o_rx_data(rxd), .o_rx_valid(rxv), .o_rx_data_en(rx_en),
      .o_lane_multifunction_output(mf), .o_pd_tx(pd_tx), .o_pd_rx(pd_rx)
   );

   task automatic end_sim;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cnt++;
      if (cnt == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // One APB transfer, read data and error taken at the completing edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge i_clk);
   endtask

   // Twenty serial bits of one lane, starting at a word boundary
   task automatic cap(input int ln);
      @(negedge i_clk);
      while (wload !== 1'b1) @(negedge i_clk);
      for (int k = 0; k < 20; k++) begin
         @(negedge i_clk);
         bits[k] = ser_out[ln];
      end
      @(posedge i_clk);
   endtask

   task automatic prbs_chk;
      logic bad;
      bad = 1'b0;
      for (int k = 7; k < 20; k++) bad |= bits[k] ^ bits[k-7] ^ bits[k-6];
      chk("prbs run", 40'h0, bad);
      chk("prbs live", 40'h1, |bits);
   endtask

   task automatic vwait;
      @(negedge i_clk);
      while (rxv !== 4'hF) @(negedge i_clk);
   endtask

   initial begin
      logic [31:0] col [4];
      col = '{32'h44332211, 32'h7C7C7C7C, 32'hBCBCBCBC, 32'h1C1C1C1C};
      cyc(2);
      i_nrst <= 1'b1;
      cyc(1);
      apb(1'b0, 8'h40, 32'h0);
      chk("gcfg reset", 40'h880, rd);
      apb(1'b0, 8'h58, 32'h0);
      chk("mode reset", 40'h1, rd[11:8]);
      apb(1'b0, 8'h54, 32'h0);
      chk("unmapped err", 40'h1, er);
      chk("unmapped data", 40'h0, rd);
      for (int m = 0; m < 4; m++) begin
         pa <= m[1];
         pb <= m[0];
         cyc(4);
         chk("ser_en", (m == 2) ? 4'h0 : 4'hF, ser_en);
         chk("rx_en", m != 1, rx_en);
         chk("pd_tx", m == 2, pd_tx);
         chk("pd_rx", m == 1, pd_rx);
         if (m == 3) begin
            @(negedge i_clk);
            s0 = ser_in;
            repeat (8) begin
               @(negedge i_clk);
               chk("repeat", s0, ser_out);
               s0 = ser_in;
            end
            cyc(1);
         end
      end
      pa <= 1'b0;
      pb <= 1'b0;
      apb(1'b1, 8'h40, 32'h88A);
      cyc(2);
      chk("ovr pd_tx", 40'h1, pd_tx);
      apb(1'b1, 8'h40, 32'h880);
      cap(0);
      chk("enc word", {2{10'h2B5}}, bits);
      apb(1'b1, 8'h40, 32'h800);
      cap(2);
      chk("bus word", {2{10'h0CA}}, bits);
      apb(1'b1, 8'h40, 32'h880);
      apb(1'b1, 8'h44, 32'h4);
      cap(0);
      prbs_chk();
      cap(1);
      chk("lane B word", {2{10'h2B5}}, bits);
      ste <= 1'b1;
      cap(3);
      prbs_chk();
      ste <= 1'b0;
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, 8'h44, p << 4);
         cyc(2);
         chk("pre lo", p[0], prl[0]);
         chk("pre hi", p[1], prh[0]);
      end
      apb(1'b1, 8'h50, 32'h10);
      cyc(2);
      chk("pre D", 40'h1, {prh[3], prl[3]});
      vwait();
      for (int c = 0; c < 4; c++) begin
         @(posedge i_clk);
         dd <= col[c];
         dk <= (c == 0) ? 4'h0 : 4'hF;
         dv <= 1'b1;
      end
      @(posedge i_clk);
      dv <= 1'b0;
      vwait();
      chk("data col", {10'h044, 10'h033, 10'h022, 10'h011}, rxd);
      repeat (3) begin
         vwait();
         chk("idle col", {4{10'h107}}, rxd);
      end
      cyc(1);
      apb(1'b0, 8'h58, 32'h0);
      chk("deletions", 40'h1, rd[22:19]);
      s0 = rd[18:15];
      cyc(40);
      apb(1'b0, 8'h58, 32'h0);
      chk("ins grow", 40'h1, rd[18:15] != s0);
      apb(1'b1, 8'h40, 32'h080);
      apb(1'b0, 8'h58, 32'h0);
      s0 = rd[18:15];
      cyc(40);
      apb(1'b0, 8'h58, 32'h0);
      chk("ins held", s0, rd[18:15]);
      apb(1'b1, 8'h40, 32'h980);
      for (int w = 0; w < 2; w++) begin
         vwait();
         bits[w*10 +: 10] = rxd[9:0];
      end
      prbs_chk();
      cyc(1);
      apb(1'b1, 8'h40, 32'hA80);
      sen <= 1'b1;
      cyc(20);
      chk("pass held", 40'hF, mf);
      err <= 4'h4;
      @(posedge i_clk);
      err <= 4'h0;
      cyc(20);
      chk("pass latched", 40'hB, mf);
      sen <= 1'b0;
      cyc(20);
      chk("pass freed", 40'hF, mf);
      apb(1'b1, 8'h40, 32'h880);
      cyc(3);
      chk("mf off", 40'h0, mf);
      end_sim();
   end
endmodule
